// file: hdl/spp_pkg.sv
package spp_pkg;

  // ==========================================================================
  // widths and timing
  // ==========================================================================
  localparam int          PIX_W        = 12;
  localparam int          DIM_W        = 12;
  localparam int          LN_W         = 14;
  localparam int          COL_W        = 13;
  localparam int          DARK_COLS    = 16;
  localparam int          DARK_LOG     = 4;
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned PIX_MAX_HZ   = 99_000_000;
  localparam int unsigned PCLK_DIV     = 2;

  // ==========================================================================
  // strap address and reset values
  // ==========================================================================
  // upper address bits: value is arbitrary
  localparam logic [4:0]  ADDR_BASE    = 5'h17;
  localparam logic [6:0]  ADDR_RST     = 7'h00;
  localparam logic [PIX_W-1:0] DATA_RST  = 12'h000;
  localparam logic [PIX_W-1:0] BLACK_RST = 12'h000;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [1:0] {
    SPP_GR = 2'h0,
    SPP_R  = 2'h1,
    SPP_B  = 2'h2,
    SPP_GB = 2'h3
  } spp_color_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_ACT  = 2'b10
  } spp_state_t;

  typedef struct packed {
    logic             fv;
    logic             lv;
    spp_color_t       color;
    logic [PIX_W-1:0] data;
  } spp_pix_t;

  typedef struct packed {
    logic [DIM_W-1:0] cols;
    logic [DIM_W-1:0] rows;
    logic [DIM_W-1:0] hblank;
    logic [DIM_W-1:0] vblank;
    logic [DIM_W-1:0] exp_lines;
    logic             snapshot;
    logic             global_release_shutter;
  } spp_cfg_t;

  typedef struct packed {
    logic             rst;
    logic             glob;
    logic             rd;
    logic [DIM_W-1:0] addr_rst;
    logic [DIM_W-1:0] addr_rd;
  } spp_row_t;

  localparam spp_pix_t PIX_RST = '{fv: 1'b0, lv: 1'b0, color: SPP_GR, data: DATA_RST};
  localparam spp_row_t ROW_RST = '{rst: 1'b0, glob: 1'b0, rd: 1'b0,
                                   addr_rst: 12'h000, addr_rd: 12'h000};

endpackage

// file: hdl/spp_pixel_port.sv
`timescale 1ns/10ps
// Summary of operation
// - pixel words are 12 bits wide, bit 11 most significant
// - frame window high over active lines and their blanking, low in vertical blanking
// - line window high only while active pixels of a line are output
// - in snapshot mode an idle trigger yields one output frame; all triggers during a frame together yield one further frame
// - exposure strobe high only while all pixels expose together in snapshot
// - low level on master reset pin resets the whole block
// - rows are reset then read in order; gap between them is exposure
// - in snapshot mode, global release starts exposure of all rows at once
// - consecutive rows alternate green/red and blue/green sequences
// - one pixel per pixel clock, pixel clock at most 99 MHz
// - dark pixels feed the black level offset correction
// - bus address taken from the two address strap pins
// - horizontal and vertical blanking lengths are programmable
// - even rows carry greenR/red, odd rows blue/greenB
module spp_pixel_port
  import spp_pkg::*;
#(
  parameter int unsigned CLK_FREQ = CLK_HZ
) (
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             sys_rst_i,
  // device pins
  input  wire logic             master_reset_n_i,
  input  wire logic             snapshot_trigger_i,
  input  wire logic             bus_address_strap_0_i,
  input  wire logic             bus_address_strap_1_i,
  // configuration
  input  wire spp_cfg_t         cfg_i,
  // pixel source
  input  wire logic [PIX_W-1:0] adc_pix_i,
  output logic                  adc_take_o,
  // pixel port
  output logic                  forwarded_sample_clock_o,
  output spp_pix_t              pix_o,
  output logic                  exposure_strobe_o,
  // array control and bus address
  output spp_row_t              row_o,
  output logic [6:0]            bus_addr_o
);

  // ==========================================================================
  // elaboration checks
  // ==========================================================================
  if (CLK_FREQ / PCLK_DIV > PIX_MAX_HZ) begin : g_rate_chk
    $error("pixel clock above the supported rate");
  end
  if ((1 << DARK_LOG) != DARK_COLS) begin : g_dark_chk
    $error("dark column count must be a power of two");
  end

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic       trig_q_ff;
  logic       soft_rst;
  logic       trig_rise;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_ff  <= 4'h0;
      sync2_ff  <= 4'h0;
      trig_q_ff <= 1'b0;
    end else begin
      sync1_ff  <= {bus_address_strap_1_i, bus_address_strap_0_i,
                    snapshot_trigger_i, master_reset_n_i};
      sync2_ff  <= sync1_ff;
      trig_q_ff <= sync2_ff[1];
    end
  end

  assign soft_rst  = !sync2_ff[0];
  assign trig_rise = sync2_ff[1] && !trig_q_ff;

  // ==========================================================================
  // frame and line sequencer
  // ==========================================================================
  spp_state_t        state_ff, nxt_state;
  logic              pclk_ff, nxt_pclk;
  logic [COL_W-1:0]  col_ff, nxt_col;
  logic [LN_W-1:0]   g_ff, nxt_g;
  logic              pend_ff, nxt_pend;
  logic              tick;
  logic              act;
  logic [COL_W-1:0]  line_len;
  logic [LN_W-1:0]   frame_len;
  logic [LN_W-1:0]   exp_w;
  logic [LN_W-1:0]   rows_w;
  logic [LN_W-1:0]   last_g;

  assign tick      = !pclk_ff;
  assign act       = (state_ff == S_ACT);
  assign exp_w     = {2'h0, cfg_i.exp_lines};
  assign rows_w    = {2'h0, cfg_i.rows};
  assign line_len  = COL_W'(DARK_COLS) + {1'b0, cfg_i.cols} + {1'b0, cfg_i.hblank};
  assign frame_len = rows_w + {2'h0, cfg_i.vblank};
  assign last_g    = cfg_i.snapshot ? exp_w + frame_len - 14'h0001 : frame_len - 14'h0001;

  always_comb begin
    nxt_pclk  = !pclk_ff;
    nxt_state = state_ff;
    nxt_col   = col_ff;
    nxt_g     = g_ff;
    nxt_pend  = cfg_i.snapshot && (pend_ff || trig_rise);
    unique case (state_ff)
      S_IDLE: begin
        if (tick && (!cfg_i.snapshot || pend_ff)) begin
          nxt_state = S_ACT;
          nxt_col   = '0;
          nxt_g     = '0;
          // a trigger arriving now is kept for the next frame
          nxt_pend  = cfg_i.snapshot && trig_rise;
        end
      end
      S_ACT: begin
        if (tick) begin
          if (col_ff == line_len - 13'h0001) begin
            nxt_col = '0;
            if (g_ff == last_g) begin
              nxt_g = '0;
              if (cfg_i.snapshot) begin
                nxt_state = S_IDLE;
              end
            end else begin
              nxt_g = g_ff + 14'h0001;
            end
          end else begin
            nxt_col = col_ff + 13'h0001;
          end
        end
      end
    endcase
    if (soft_rst) begin
      nxt_state = S_IDLE;
      nxt_pclk  = 1'b0;
      nxt_col   = '0;
      nxt_g     = '0;
      nxt_pend  = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_ff <= S_IDLE;
      pclk_ff  <= 1'b0;
      col_ff   <= '0;
      g_ff     <= '0;
      pend_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pclk_ff  <= nxt_pclk;
      col_ff   <= nxt_col;
      g_ff     <= nxt_g;
      pend_ff  <= nxt_pend;
    end
  end

  // ==========================================================================
  // row control, strobe and pixel output
  // ==========================================================================
  spp_pix_t          pix_ff, nxt_pix;
  spp_row_t          row_ff, nxt_row;
  logic              strobe_ff, nxt_strobe;
  logic [DIM_W-1:0]  pix_row_ff, nxt_pix_row;
  logic              rd_on;
  logic [DIM_W-1:0]  rd_row;
  logic              line_start;
  logic              grr_en;
  logic [LN_W-1:0]   rst_t;
  logic              dark_px;
  logic              act_px;
  logic [COL_W-1:0]  act_col;
  logic [PIX_W-1:0]  black_ff, nxt_black;
  logic [PIX_W+DARK_LOG-1:0] acc_ff, nxt_acc;
  logic [PIX_W+DARK_LOG-1:0] acc_sum;
  logic [PIX_W-1:0]  corr;

  assign grr_en     = cfg_i.snapshot && cfg_i.global_release_shutter;
  assign line_start = act && tick && (col_ff == '0);
  assign dark_px    = (col_ff < COL_W'(DARK_COLS));
  assign act_px     = !dark_px && (col_ff < COL_W'(DARK_COLS) + {1'b0, cfg_i.cols});
  assign act_col    = col_ff - COL_W'(DARK_COLS);
  assign adc_take_o = tick && rd_on && (dark_px || act_px);
  assign corr       = (adc_pix_i > black_ff) ? adc_pix_i - black_ff : DATA_RST;

  always_comb begin
    rst_t = g_ff + exp_w;
    if (rst_t >= frame_len) begin
      rst_t = rst_t - frame_len;
    end
    if (cfg_i.snapshot) begin
      rd_on  = act && (g_ff >= exp_w) && (g_ff < exp_w + rows_w);
      rd_row = DIM_W'(g_ff - exp_w);
    end else begin
      rd_on  = act && (g_ff < rows_w);
      rd_row = g_ff[DIM_W-1:0];
    end
  end

  always_comb begin
    nxt_pix      = pix_ff;
    nxt_pix_row  = pix_row_ff;
    nxt_row      = ROW_RST;
    nxt_row.addr_rst = row_ff.addr_rst;
    nxt_row.addr_rd  = row_ff.addr_rd;
    nxt_acc      = acc_ff;
    nxt_black    = black_ff;
    acc_sum      = ((col_ff == '0) ? '0 : acc_ff) + {{DARK_LOG{1'b0}}, adc_pix_i};
    if (line_start) begin
      // reset sweep runs ahead of readout by the exposure in lines
      if (cfg_i.snapshot) begin
        nxt_row.rst      = !grr_en && (g_ff < rows_w);
        nxt_row.addr_rst = g_ff[DIM_W-1:0];
      end else begin
        nxt_row.rst      = (rst_t < rows_w);
        nxt_row.addr_rst = rst_t[DIM_W-1:0];
      end
      nxt_row.glob    = grr_en && (g_ff == '0);
      nxt_row.rd      = rd_on;
      nxt_row.addr_rd = rd_row;
    end
    nxt_strobe = act && cfg_i.snapshot && (g_ff < exp_w) && (grr_en || g_ff >= rows_w);
    if (tick) begin
      nxt_pix.fv    = rd_on;
      nxt_pix.lv    = rd_on && act_px;
      nxt_pix.data  = (rd_on && act_px) ? corr : DATA_RST;
      nxt_pix.color = spp_color_t'({rd_row[0], act_col[0]});
      nxt_pix_row   = rd_row;
      if (rd_on && dark_px) begin
        nxt_acc = acc_sum;
        if (col_ff == COL_W'(DARK_COLS - 1)) begin
          nxt_black = acc_sum[PIX_W+DARK_LOG-1:DARK_LOG];
        end
      end
    end
    if (soft_rst) begin
      nxt_pix     = PIX_RST;
      nxt_pix_row = '0;
      nxt_row     = ROW_RST;
      nxt_strobe  = 1'b0;
      nxt_acc     = '0;
      nxt_black   = BLACK_RST;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pix_ff     <= PIX_RST;
      pix_row_ff <= '0;
      row_ff     <= ROW_RST;
      strobe_ff  <= 1'b0;
      acc_ff     <= '0;
      black_ff   <= BLACK_RST;
    end else begin
      pix_ff     <= nxt_pix;
      pix_row_ff <= nxt_pix_row;
      row_ff     <= nxt_row;
      strobe_ff  <= nxt_strobe;
      acc_ff     <= nxt_acc;
      black_ff   <= nxt_black;
    end
  end

  // ==========================================================================
  // address straps
  // ==========================================================================
  logic       strap_done_ff, nxt_strap_done;
  logic [6:0] addr_ff, nxt_addr;

  always_comb begin
    nxt_strap_done = 1'b1;
    nxt_addr       = addr_ff;
    if (!strap_done_ff) begin
      nxt_addr = {ADDR_BASE, sync2_ff[3], sync2_ff[2]};
    end
    if (soft_rst) begin
      nxt_strap_done = 1'b0;
      nxt_addr       = ADDR_RST;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strap_done_ff <= 1'b0;
      addr_ff       <= ADDR_RST;
    end else begin
      strap_done_ff <= nxt_strap_done;
      addr_ff       <= nxt_addr;
    end
  end

  assign forwarded_sample_clock_o = pclk_ff;
  assign pix_o             = pix_ff;
  assign exposure_strobe_o = strobe_ff;
  assign row_o             = row_ff;
  assign bus_addr_o        = addr_ff;

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  logic [DIM_W-1:0] rd_last_ff;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_last_ff <= '0;
    end else if (row_ff.rd) begin
      rd_last_ff <= row_ff.addr_rd;
    end
  end

  a_data_blank: assert property (!pix_ff.lv |-> pix_ff.data == DATA_RST)
    else $error("pixel data not zero in blanking");
  a_line_in_frame: assert property (pix_ff.lv |-> pix_ff.fv)
    else $error("line window high outside frame window");
  // a pin reset clears the outputs on whatever edge it lands
  a_out_on_rise: assert property (!$stable(pix_ff) |-> $rose(pclk_ff) || $past(soft_rst))
    else $error("pixel outputs changed away from the rising clock edge");
  a_pix_rate: assert property (adc_take_o |=> !adc_take_o ##1 1'b1)
    else $error("more than one pixel per pixel clock");
  a_color_alt: assert property (pix_ff.lv && $past(pix_ff.lv, 2) &&
                                pix_row_ff == $past(pix_row_ff, 2)
                                |-> pix_ff.color[0] != $past(pix_ff.color[0], 2))
    else $error("bayer colors do not alternate");
  a_color_row: assert property (pix_ff.lv |-> pix_ff.color[1] == pix_row_ff[0])
    else $error("bayer row phase wrong");
  a_strobe_dark: assert property (strobe_ff |-> cfg_i.snapshot && !pix_ff.fv)
    else $error("strobe outside common exposure");
  a_grr_strobe: assert property (row_ff.glob && cfg_i.exp_lines != '0
                                 |-> ##[0:2] strobe_ff)
    else $error("no strobe after global release");
  a_reset_pin: assert property (soft_rst |=> !pix_ff.fv && !strobe_ff && state_ff == S_IDLE)
    else $error("reset pin did not clear the port");
  a_row_order: assert property (row_ff.rd |-> row_ff.addr_rd == '0 ||
                                row_ff.addr_rd == rd_last_ff + 12'h001)
    else $error("rows read out of order");
  a_one_frame: assert property (cfg_i.snapshot && $rose(state_ff == S_ACT) |-> $past(pend_ff))
    else $error("snapshot frame without trigger");
  a_addr_strap: assert property ($rose(strap_done_ff) |-> bus_addr_o[1:0] == $past(sync2_ff[3:2]))
    else $error("bus address does not follow straps");

  c_snap_frame: cover property (cfg_i.snapshot && $fell(state_ff == S_ACT));
  c_grr_strobe: cover property (grr_en && $fell(strobe_ff));
  c_cont_wrap:  cover property (!cfg_i.snapshot && $fell(pix_ff.fv));
  c_trig_held:  cover property (act && trig_rise);

endmodule

// file: sim/spp_capture_model.sv
`timescale 1ns/10ps
module spp_capture_model
  import spp_pkg::*;
(
  // pixel link
  input  wire logic     fclk_i,
  input  wire spp_pix_t pix_i,
  // captured word
  output spp_pix_t      cap_o,
  output int            cnt_o
);
  // ==========================================================================
  // capture unit
  // ==========================================================================
  initial cap_o = PIX_RST;
  initial cnt_o = 0;

  // data, frame and line window taken on the falling forwarded clock edge
  always @(negedge fclk_i) begin
    cap_o = pix_i;
    cnt_o = cnt_o + 1;
  end
endmodule

// file: sim/tb_spp_pixel_port.sv
`timescale 1ns/10ps
module tb_spp_pixel_port
  import spp_pkg::*;
;
  // ==========================================================================
  // signals
  // ==========================================================================
  localparam int               COLS   = 4;
  localparam int               LN     = 16 + COLS + 2;
  localparam logic [PIX_W-1:0] DARK_V = 12'h040;
  logic             mclk = 0, rst = 1, mrst_n = 1, trig = 0, s0 = 0, s1 = 0;
  logic             take, fclk, strobe, st_q = 0, chk = 0;
  logic [PIX_W-1:0] adc = DARK_V, a;
  logic [6:0]       addr;
  logic [31:0]      lf = 32'h6618;
  spp_cfg_t         cfg;
  spp_pix_t         pix, cap, e;
  spp_row_t         row;
  int               cap_cnt, n_fail = 0, comparisons = 0;
  int               takes = 0, tick = -1, g, p, fv_ticks = 0, strobes = 0, globs = 0, rsts = 0;
  realtime          t_last;
  logic [PIX_W-1:0] act_q[$];

  always #5 mclk = ~mclk;

  spp_pixel_port spp_pixel_port_i (
    .mclk_i(mclk), .sys_rst_i(rst), .master_reset_n_i(mrst_n), .snapshot_trigger_i(trig),
    .bus_address_strap_0_i(s0), .bus_address_strap_1_i(s1), .cfg_i(cfg), .adc_pix_i(adc),
    .adc_take_o(take), .forwarded_sample_clock_o(fclk), .pix_o(pix),
    .exposure_strobe_o(strobe), .row_o(row), .bus_addr_o(addr));

  spp_capture_model spp_capture_model_i (.fclk_i(fclk), .pix_i(pix), .cap_o(cap),
                                         .cnt_o(cap_cnt));

  // ==========================================================================
  // helpers
  // ==========================================================================
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic check(input bit ok, input string msg);
    comparisons++;
    if (!ok) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic fire;
    @(posedge mclk) #1 trig = 1;
    repeat (4) @(posedge mclk);
    #1 trig = 0;
  endtask

  // ==========================================================================
  // pixel source: 16 dark values then random active values per line
  // ==========================================================================
  always @(negedge mclk) begin
    if (strobe === 1'b1 && !st_q) strobes++;
    if (strobe === 1'b1 && pix.fv !== 1'b0) check(0, "strobe during readout");
    st_q = (strobe === 1'b1);
    if (row.glob === 1'b1) globs++;
    if (row.rst === 1'b1) rsts++;
    if (take === 1'b1) begin
      if (takes % (16 + COLS) >= 16) act_q.push_back(adc);
      takes++;
      lf = lfsr(lf);
      @(posedge mclk) #1 adc = (takes % (16 + COLS) < 16) ? DARK_V : lf[11:0];
    end
  end

  // ==========================================================================
  // reference model of the continuous stream
  // ==========================================================================
  always @(cap_cnt) begin
    // let the captured word settle behind the count
    #1;
    if (cap.fv === 1'b1) fv_ticks++;
    if (chk && tick < 0 && cap.fv === 1'b1) tick = 0;
    if (chk && tick >= 0) begin
      g = (tick / LN) % 3;
      p = tick % LN;
      e.fv = (g < 2);
      e.lv = e.fv && p >= 16 && p < 16 + COLS;
      e.color = e.lv ? spp_color_t'({g[0], p[0]}) : cap.color;
      e.data = '0;
      if (e.lv) begin
        if (act_q.size() == 0) check(0, "no pixel taken");
        else a = act_q.pop_front();
        e.data = (a > DARK_V) ? a - DARK_V : '0;
      end
      // black level is set from the first line's dark pixels before its active pixels; that line's data is not compared
      if (tick < LN) e.data = cap.data;
      check(cap === e, "pixel word");
      if (tick > 0) check($realtime - t_last == 20.0, "pixel rate");
      tick++;
    end
    t_last = $realtime;
  end

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    cfg = '{cols: 12'h004, rows: 12'h002, hblank: 12'h002, vblank: 12'h001,
            exp_lines: 12'h001, snapshot: 1'b0, global_release_shutter: 1'b0};
    lf = lfsr(lf);
    s0 = lf[0];
    s1 = lf[1];
    repeat (12) @(posedge mclk);
    #1 rst = 0;
    chk = 1;
    repeat (8) @(posedge mclk);
    check(addr === {ADDR_BASE, s1, s0}, "strap address");
    repeat (4 * 3 * LN * 2) @(posedge mclk);
    check(tick >= 3 * 3 * LN, "stream stalled");
    chk = 0;
    // pin reset in mid-run; config changes only while the port is held idle
    #1 mrst_n = 0;
    s0 = ~s0;
    s1 = ~s1;
    repeat (4) @(posedge mclk);
    check(pix === PIX_RST && addr === ADDR_RST && strobe === 1'b0, "master reset");
    // snapshot with global release, longer line blanking
    #1 cfg = '{cols: 12'h004, rows: 12'h002, hblank: 12'h003, vblank: 12'h001,
               exp_lines: 12'h002, snapshot: 1'b1, global_release_shutter: 1'b1};
    mrst_n = 1;
    repeat (8) @(posedge mclk);
    check(addr === {ADDR_BASE, s1, s0}, "strap address");
    fv_ticks = 0;
    strobes = 0;
    globs = 0;
    rsts = 0;
    repeat (600) @(posedge mclk);
    check(fv_ticks == 0 && strobes == 0, "frame without trigger");
    fire();
    repeat (60) @(posedge mclk);
    fire();
    repeat (60) @(posedge mclk);
    fire();
    repeat (1500) @(posedge mclk);
    check(fv_ticks == 2 * 2 * (16 + COLS + 3), "frames per trigger");
    check(strobes == 2, "strobe per frame");
    check(globs == 2 && rsts == 0, "global release per frame");
    // snapshot with rolling row reset, exposure longer than readout
    #1 cfg = '{cols: 12'h004, rows: 12'h002, hblank: 12'h003, vblank: 12'h001,
               exp_lines: 12'h003, snapshot: 1'b1, global_release_shutter: 1'b0};
    fv_ticks = 0;
    strobes = 0;
    globs = 0;
    rsts = 0;
    fire();
    repeat (700) @(posedge mclk);
    check(fv_ticks == 2 * (16 + COLS + 3), "rolling snapshot frame");
    check(strobes == 1 && globs == 0, "rolling snapshot strobe");
    check(rsts == 2, "row resets per frame");
    end_sim();
  end

  initial begin
    #60us;
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end
endmodule
